//--- spr_defs.svh
`ifndef SPR_DEFS_SVH
`define SPR_DEFS_SVH

// ==========================================
// serial word layout
`define SPR_WORD_BITS 30
`define SPR_PIX_BITS 24
`define SPR_DE_BIT 24
`define SPR_HS_BIT 25
`define SPR_VS_BIT 26
`define SPR_PARITY_BIT 27

// ==========================================
// lane counts
`define SPR_LANES_1 2'h1
`define SPR_LANES_2 2'h2
`define SPR_LANES_3 2'h3

// ==========================================
// timing
`define SPR_CLK_NS 50
`define SPR_LOSS_NS 2000
`define SPR_LOSS_CYC ((`SPR_LOSS_NS + `SPR_CLK_NS - 1) / `SPR_CLK_NS)
`define SPR_LOCK_PERIODS 4

// ==========================================
// static output levels without a locked link
`define SPR_STATIC_PIX 24'hFFFFFF
`define SPR_STATIC_SYNC 1'h1
`define SPR_STATIC_DE 1'h0
`define SPR_STATIC_PCLK 1'h0

// ==========================================
// register map
`define SPR_REG_STATUS 8'h00
`define SPR_REG_MASK 8'h04
`define SPR_REG_STATE 8'h08
`define SPR_EV_BITS 3
`define SPR_EV_PERR 0
`define SPR_EV_LOCK 1
`define SPR_EV_LOST 2
`define SPR_MASK_RESET 3'h0

`endif

//--- spr_pkg.sv
`include "spr_defs.svh"

package spr_pkg;

  typedef enum logic [1:0] {mode_shutdown, mode_standby, mode_acquire, mode_active} spr_mode_t;

  // lane count from the two select pins
  function automatic logic [1:0] spr_lanes(input logic sel_a, input logic sel_b);
    spr_lanes = (sel_a == sel_b) ? `SPR_LANES_1 : (sel_b ? `SPR_LANES_3 : `SPR_LANES_2);
  endfunction

  // bit clocks per serial word
  function automatic logic [4:0] spr_cpw(input logic [1:0] lanes);
    logic [4:0] cpw;
    cpw = 5'(`SPR_WORD_BITS);
    if (lanes == `SPR_LANES_3) begin
      cpw = 5'(`SPR_WORD_BITS / 3);
    end else if (lanes == `SPR_LANES_2) begin
      cpw = 5'(`SPR_WORD_BITS / 2);
    end
    return cpw;
  endfunction

  function automatic logic [23:0] spr_rev24(input logic [23:0] v);
    logic [23:0] r;
    r = 24'h000000;
    for (int i = 0; i < 24; i++) begin
      r[i] = v[23 - i];
    end
    return r;
  endfunction

endpackage

//--- spr_lock.sv
`timescale 1ns/1ps
`include "spr_defs.svh"

// ==========================================
// link clock presence and lock tracking
module spr_lock #(
  parameter int LOSS_CYC = `SPR_LOSS_CYC,
  parameter int LOCK_PERIODS = `SPR_LOCK_PERIODS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // link
  input wire logic enable,
  input wire logic link_clk_in,
  input wire logic [4:0] cpw,
  // status
  output logic clk_edge,
  output logic present_q,
  output logic locked_q
);
  localparam int PW = $clog2(LOSS_CYC + 1);
  localparam int GW = $clog2(LOCK_PERIODS + 1);
  localparam logic [PW-1:0] LOSS = PW'(LOSS_CYC);
  localparam logic [GW-1:0] LOCKN = GW'(LOCK_PERIODS);

  logic prev_q;
  logic [PW-1:0] per_q, per_d;
  logic [GW-1:0] good_q, good_d;
  logic period_ok;

  assign clk_edge = link_clk_in & ~prev_q;
  assign per_d = clk_edge ? PW'(1) : ((per_q == LOSS) ? per_q : per_q + PW'(1));
  assign period_ok = (per_q == PW'(cpw));
  // a clock parked high by the far end stops edges, so presence times out (standby)
  assign good_d = (!enable || per_q == LOSS) ? '0 :
                  (!clk_edge ? good_q :
                  (!period_ok ? '0 : ((good_q == LOCKN) ? good_q : good_q + GW'(1))));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b1;
      per_q <= LOSS;
      good_q <= '0;
      present_q <= 1'b0;
      locked_q <= 1'b0;
    end else begin
      prev_q <= link_clk_in;
      per_q <= per_d;
      good_q <= good_d;
      present_q <= (per_d != LOSS);
      locked_q <= (good_d == LOCKN);
    end
  end

  property p_bad_period_unlocks;
    @(posedge sys_clk) disable iff (rst) clk_edge && !period_ok |=> !locked_q;
  endproperty
  a_bad_period_unlocks: assert property (p_bad_period_unlocks) else $error("lock kept on bad period");
endmodule

//--- spr_deser.sv
`timescale 1ns/1ps
`include "spr_defs.svh"

// ==========================================
// single shift register fed by up to three lanes
module spr_deser #(
  parameter int WB = `SPR_WORD_BITS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // serial side
  input wire logic [2:0] lane_data,
  input wire logic [1:0] lane_cnt,
  input wire logic [4:0] cpw,
  input wire logic word_start,
  // word side
  output logic word_done_q,
  output logic [WB-1:0] word_q
);
  logic [WB-1:0] sr_q, sr_d, base;
  logic [4:0] cnt_q, cnt_d;
  logic word_done_d;

  // word boundary is the link clock edge; lane zero carries the leading bit of each group
  assign base = word_start ? '0 : sr_q;
  assign sr_d = (lane_cnt == `SPR_LANES_3) ? {base[WB-4:0], lane_data[0], lane_data[1], lane_data[2]} :
                (lane_cnt == `SPR_LANES_2) ? {base[WB-3:0], lane_data[0], lane_data[1]} :
                {base[WB-2:0], lane_data[0]};
  assign cnt_d = word_start ? 5'h1 : cnt_q + 5'h1;
  assign word_done_d = !word_start && (cnt_q == cpw - 5'h1);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sr_q <= '0;
      cnt_q <= 5'h0;
      word_done_q <= 1'b0;
      word_q <= '0;
    end else begin
      sr_q <= sr_d;
      cnt_q <= cnt_d;
      word_done_q <= word_done_d;
      if (word_done_d) begin
        word_q <= sr_d;
      end
    end
  end

  property p_word_spacing;
    @(posedge sys_clk) disable iff (rst) word_done_q && !word_start |=> !word_done_q [*8];
  endproperty
  a_word_spacing: assert property (p_word_spacing) else $error("words closer than a word time");
endmodule

//--- spr_rx.sv
`timescale 1ns/1ps
`include "spr_defs.svh"

// ==========================================
// What this block does
// - Each 30-bit serial word is built up in one shift register fed by the active lanes.
// - A word's 24 pixel bits and three sync bits reach the parallel bus only after parity is checked.
// - A word with good parity leaves the parity error output low.
// - A word with bad parity pulses the parity error output and its pixel is dropped.
// - On bad parity the previously shown word stays on the bus for one more pixel clock.
// - The block locks to the incoming link clock and runs the shift at the lane bit rate.
// - Data is shifted at the bit rate and a recreated pixel clock goes out with the parallel data.
// - Without a link clock the pixel clock, data valid and parity error flag are low and the pixel and sync outputs high.
// - The order input selects RGB most significant first or the full reversal with blue first.
// - The two lane selects choose one, two or three lanes and the sender uses the same count.
// - The receiver enable puts the block in a shutdown mode apart from active and standby.
// - A sender that parks its clock drops the block into standby with no pin change.
// - Enable high runs the receiver; enable low drops the output drivers and the lock.
// - Lane zero always runs, lane one when exactly one select is high, lane two only for 0/1.
// - The edge select aligns the bus to the rising or the falling pixel clock edge.
module spr_rx #(
  parameter int LOSS_CYC = `SPR_LOSS_CYC,
  parameter int LOCK_PERIODS = `SPR_LOCK_PERIODS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // serial link
  input wire logic link_clk_in,
  input wire logic serial_lane_zero,
  input wire logic serial_lane_one,
  input wire logic serial_lane_two,
  // control pins
  input wire logic lane_count_sel_a,
  input wire logic lane_count_sel_b,
  input wire logic receiver_on,
  input wire logic out_clock_edge_sel,
  input wire logic bus_order_sel,
  // parallel bus
  output logic [23:0] pixel_bus,
  output logic vertical_sync_out,
  output logic horizontal_sync_out,
  output logic data_valid_window,
  output logic pixel_clock_out,
  output logic parity_error_flag,
  output logic out_drive_en,
  output spr_pkg::spr_mode_t rx_mode,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rd_data,
  output logic irq
);
  import spr_pkg::*;

  // ==========================================
  // lane selection and link tracking
  logic [1:0] lane_cnt;
  logic [4:0] cpw;
  logic [2:0] lane_data;
  logic clk_edge, lk_present, lk_locked;
  logic word_done;
  logic [`SPR_WORD_BITS-1:0] word;

  assign lane_cnt = spr_lanes(lane_count_sel_a, lane_count_sel_b);
  assign cpw = spr_cpw(lane_cnt);
  // unused lanes are forced low so floating inputs never reach the shifter
  assign lane_data = {serial_lane_two & (lane_cnt == `SPR_LANES_3),
                      serial_lane_one & (lane_cnt != `SPR_LANES_1),
                      serial_lane_zero};

  spr_lock #(
    .LOSS_CYC(LOSS_CYC),
    .LOCK_PERIODS(LOCK_PERIODS)
  ) u_lock (
    .sys_clk(sys_clk),
    .rst(rst),
    .enable(receiver_on),
    .link_clk_in(link_clk_in),
    .cpw(cpw),
    .clk_edge(clk_edge),
    .present_q(lk_present),
    .locked_q(lk_locked)
  );

  spr_deser u_deser (
    .sys_clk(sys_clk),
    .rst(rst),
    .lane_data(lane_data),
    .lane_cnt(lane_cnt),
    .cpw(cpw),
    .word_start(clk_edge),
    .word_done_q(word_done),
    .word_q(word)
  );

  // ==========================================
  // operating mode
  spr_mode_t mode_q, mode_d;
  logic act;

  assign mode_d = !receiver_on ? mode_shutdown :
                  (!lk_present ? mode_standby :
                  (!lk_locked ? mode_acquire : mode_active));
  assign act = (mode_d == mode_active);

  // ==========================================
  // parity check and output word
  logic parity_ok, take_good, take_bad;
  logic [23:0] pix_new, pix_q, pix_d;
  logic vs_q, vs_d, hs_q, hs_d, de_q, de_d;
  logic perr_q, perr_d;
  logic [4:0] phase_q, phase_d;
  logic pclk_q, pclk_d;
  logic drive_q;

  // even parity over data and the parity bit itself
  assign parity_ok = ~^word[`SPR_PARITY_BIT:0];
  assign take_good = act && word_done && parity_ok;
  assign take_bad = act && word_done && !parity_ok;
  assign pix_new = bus_order_sel ? spr_rev24(word[`SPR_PIX_BITS-1:0])
                                 : word[`SPR_PIX_BITS-1:0];

  // bad words leave the held word in place for one more pixel clock
  assign pix_d = !act ? `SPR_STATIC_PIX : (take_good ? pix_new : pix_q);
  assign vs_d = !act ? `SPR_STATIC_SYNC : (take_good ? word[`SPR_VS_BIT] : vs_q);
  assign hs_d = !act ? `SPR_STATIC_SYNC : (take_good ? word[`SPR_HS_BIT] : hs_q);
  assign de_d = !act ? `SPR_STATIC_DE : (take_good ? word[`SPR_DE_BIT] : de_q);
  // flag spans one word time: set at a bad word, dropped at the next word
  assign perr_d = act && (word_done ? !parity_ok : perr_q);

  // pixel clock regenerated from the bit clock, one period per word
  assign phase_d = word_done ? 5'h0 : ((phase_q == cpw - 5'h1) ? phase_q : phase_q + 5'h1);
  assign pclk_d = act ? ((phase_d < (cpw >> 1)) ^ out_clock_edge_sel) : `SPR_STATIC_PCLK;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_q <= mode_shutdown;
      pix_q <= `SPR_STATIC_PIX;
      vs_q <= `SPR_STATIC_SYNC;
      hs_q <= `SPR_STATIC_SYNC;
      de_q <= `SPR_STATIC_DE;
      perr_q <= 1'b0;
      phase_q <= 5'h0;
      pclk_q <= `SPR_STATIC_PCLK;
      drive_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      pix_q <= pix_d;
      vs_q <= vs_d;
      hs_q <= hs_d;
      de_q <= de_d;
      perr_q <= perr_d;
      phase_q <= phase_d;
      pclk_q <= pclk_d;
      drive_q <= receiver_on;
    end
  end

  assign pixel_bus = pix_q;
  assign vertical_sync_out = vs_q;
  assign horizontal_sync_out = hs_q;
  assign data_valid_window = de_q;
  assign pixel_clock_out = pclk_q;
  assign parity_error_flag = perr_q;
  assign out_drive_en = drive_q;
  assign rx_mode = mode_q;

  // ==========================================
  // event status, mask and interrupt
  logic [`SPR_EV_BITS-1:0] ev, status_q, status_d, mask_q, mask_d;
  logic rd_status, wr_mask;
  logic [31:0] rd_word, rd_q;
  logic irq_q;

  assign ev[`SPR_EV_PERR] = take_bad;
  assign ev[`SPR_EV_LOCK] = act && (mode_q != mode_active);
  assign ev[`SPR_EV_LOST] = (mode_d == mode_standby) && (mode_q != mode_standby)
                            && (mode_q != mode_shutdown);
  assign rd_status = reg_rd && (reg_addr == `SPR_REG_STATUS);
  assign wr_mask = reg_wr && (reg_addr == `SPR_REG_MASK);
  // a new event in the clearing read's cycle survives the clear
  assign status_d = (rd_status ? '0 : status_q) | ev;
  assign mask_d = wr_mask ? reg_wr_data[`SPR_EV_BITS-1:0] : mask_q;
  assign rd_word = (reg_addr == `SPR_REG_STATUS) ? 32'(status_q) :
                   (reg_addr == `SPR_REG_MASK) ? 32'(mask_q) :
                   (reg_addr == `SPR_REG_STATE) ? 32'({lane_cnt, mode_q, lk_locked, lk_present}) :
                   32'h00000000;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_q <= '0;
      mask_q <= `SPR_MASK_RESET;
      rd_q <= 32'h00000000;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      rd_q <= reg_rd ? rd_word : 32'h00000000;
      irq_q <= |(status_d & mask_d);
    end
  end

  assign reg_rd_data = rd_q;
  assign irq = irq_q;

  // ==========================================
  // checks
  property p_good_word_no_error;
    @(posedge sys_clk) disable iff (rst) take_good |=> !perr_q;
  endproperty
  a_good_word_no_error: assert property (p_good_word_no_error) else $error("error on good word");

  property p_bad_word_flags;
    @(posedge sys_clk) disable iff (rst) take_bad |=> perr_q && $stable(pix_q) && $stable(de_q);
  endproperty
  a_bad_word_flags: assert property (p_bad_word_flags) else $error("bad word not dropped");

  property p_bad_word_held;
    @(posedge sys_clk) disable iff (rst)
      take_bad ##1 (act && !word_done) |=> $stable(pix_q) && $stable(vs_q) && $stable(hs_q);
  endproperty
  a_bad_word_held: assert property (p_bad_word_held) else $error("held word changed");

  property p_good_word_shown;
    @(posedge sys_clk) disable iff (rst)
      take_good |=> de_q == $past(word[`SPR_DE_BIT]) && vs_q == $past(word[`SPR_VS_BIT]);
  endproperty
  a_good_word_shown: assert property (p_good_word_shown) else $error("controls not shown");

  property p_swap_order;
    @(posedge sys_clk) disable iff (rst)
      take_good && bus_order_sel |=> pix_q == spr_rev24($past(word[`SPR_PIX_BITS-1:0]));
  endproperty
  a_swap_order: assert property (p_swap_order) else $error("reversed order wrong");

  property p_no_clock_static;
    @(posedge sys_clk) disable iff (rst)
      !lk_present |=> !pclk_q && !de_q && (pix_q == `SPR_STATIC_PIX) && vs_q && hs_q;
  endproperty
  a_no_clock_static: assert property (p_no_clock_static) else $error("bus not static");

  property p_shutdown;
    @(posedge sys_clk) disable iff (rst)
      !receiver_on |=> !drive_q && (mode_q == mode_shutdown) && !pclk_q;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown not entered");

  property p_error_pulse_span;
    @(posedge sys_clk) disable iff (rst) perr_q && act && !word_done |=> perr_q;
  endproperty
  a_error_pulse_span: assert property (p_error_pulse_span) else $error("error pulse cut short");

  property p_unlocked_static;
    @(posedge sys_clk) disable iff (rst) !lk_locked |=> !de_q && !perr_q && !pclk_q;
  endproperty
  a_unlocked_static: assert property (p_unlocked_static) else $error("output while unlocked");

  property p_pclk_polarity;
    @(posedge sys_clk) disable iff (rst)
      take_good && cpw > 5'h1 |=> pclk_q == !$past(out_clock_edge_sel);
  endproperty
  a_pclk_polarity: assert property (p_pclk_polarity) else $error("pixel clock edge wrong");

  property p_forward_order;
    @(posedge sys_clk) disable iff (rst)
      take_good && !bus_order_sel |=> pix_q == $past(word[`SPR_PIX_BITS-1:0]);
  endproperty
  a_forward_order: assert property (p_forward_order) else $error("forward order wrong");

  property p_hsync_shown;
    @(posedge sys_clk) disable iff (rst)
      take_good |=> hs_q == $past(word[`SPR_HS_BIT]);
  endproperty
  a_hsync_shown: assert property (p_hsync_shown) else $error("hsync not shown");

  property p_standby_static;
    @(posedge sys_clk) disable iff (rst)
      mode_q == mode_standby |-> !pclk_q && !de_q && !perr_q && (pix_q == `SPR_STATIC_PIX);
  endproperty
  a_standby_static: assert property (p_standby_static) else $error("standby bus moving");

  property p_shutdown_static;
    @(posedge sys_clk) disable iff (rst)
      mode_q == mode_shutdown |-> !pclk_q && !de_q && vs_q && hs_q;
  endproperty
  a_shutdown_static: assert property (p_shutdown_static) else $error("shutdown bus moving");

  property p_unused_lanes_low;
    @(posedge sys_clk) disable iff (rst)
      lane_cnt == `SPR_LANES_1 |-> lane_data[2:1] == 2'h0;
  endproperty
  a_unused_lanes_low: assert property (p_unused_lanes_low) else $error("idle lane leaks");

  property p_drive_on;
    @(posedge sys_clk) disable iff (rst) receiver_on |=> drive_q;
  endproperty
  a_drive_on: assert property (p_drive_on) else $error("drivers not enabled");

  property p_error_source;
    @(posedge sys_clk) disable iff (rst) $rose(perr_q) |-> $past(take_bad);
  endproperty
  a_error_source: assert property (p_error_source) else $error("error without bad word");
endmodule

//--- spr_ser_model.sv
`timescale 1ns/1ps
// ==========================================
// serializer model for the far end of the link
module spr_ser_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic [4:0] cpw,
  input wire logic [29:0] next_word,
  // link
  output logic link_clk,
  output logic [2:0] lanes
);
  logic [29:0] sh_q;
  logic [4:0] cnt_q;
  logic act_q;
  logic [2:0] junk_q;
  logic [1:0] n;
  logic l1;
  logic l2;
  assign n = (cpw == 5'h0A) ? 2'h3 : ((cpw == 5'h0F) ? 2'h2 : 2'h1);
  // parked clock sits low, so a restart always shows a clean rising edge
  assign link_clk = act_q && (cnt_q < (cpw >> 1));
  // lane0 is the most significant of each group; unused lanes toggle to expose leaks
  assign l1 = (n != 2'h1) ? sh_q[28] : junk_q[1];
  assign l2 = (n == 2'h3) ? sh_q[27] : junk_q[2];
  assign lanes = act_q ? {l2, l1, sh_q[29]} : junk_q;
  // ==========================================
  // stops only at a word boundary so no word is cut short
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sh_q <= 30'h0;
      cnt_q <= 5'h0;
      act_q <= 1'b0;
      junk_q <= 3'h5;
    end else begin
      junk_q <= ~junk_q;
      if (cnt_q == cpw - 5'h1 || !act_q) begin
        act_q <= run;
        cnt_q <= 5'h0;
        sh_q <= next_word;
      end else begin
        cnt_q <= cnt_q + 5'h1;
        sh_q <= sh_q << n;
      end
    end
  end
endmodule

//--- testbench.sv
`timescale 1ns/1ps
`include "spr_defs.svh"
module testbench;
  import spr_pkg::*;
  // ==========================================
  // signals
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b0;
  logic err_en = 1'b0;
  int edges = 0;
  int taken = 0;
  logic sel_a = 1'b0;
  logic sel_b = 1'b0;
  logic ron = 1'b1;
  logic edge_sel = 1'b0;
  logic order_sel = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wr_data = 32'h0;
  logic [29:0] next_word = 30'h0;
  logic [15:0] lfsr = 16'h0009;
  logic [15:0] r1;
  logic [15:0] r2;
  logic [29:0] w;
  logic [29:0] cw;
  logic [4:0] cpw;
  logic link_clk;
  logic [2:0] lanes;
  logic [23:0] pix;
  logic vs, hs, de, pclk, perr, drv_en, irq, bad;
  spr_mode_t rx_mode;
  spr_mode_t mode_prev = mode_shutdown;
  logic [31:0] reg_rd_data;
  logic [31:0] rd;
  logic [26:0] exp_prev;
  logic prev_ok = 1'b0;
  logic link_prev = 1'b0;
  logic ron_prev = 1'b1;
  logic rst_prev = 1'b1;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  int due_q[$];
  logic [29:0] word_q[$];
  // ==========================================
  // helpers
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [4:0] exp_cpw(input logic a, input logic b);
    return (a == b) ? 5'h1E : (a ? 5'h0F : 5'h0A);
  endfunction
  // {vs, hs, de, pixels} seen on the bus for a word
  function automatic logic [26:0] exp_out(input logic [29:0] v, input logic rev);
    logic [26:0] o;
    o = v[26:0];
    if (rev) begin
      for (int i = 0; i < 24; i++) begin
        o[i] = v[23 - i];
      end
    end
    return o;
  endfunction
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic complete_run();
    if (mismatches == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rd_data;
  endtask
  task automatic wait_mode(input spr_mode_t m, input int bound);
    for (int k = 0; k < bound && rx_mode !== m; k++) begin
      @(negedge sys_clk);
    end
    if (rx_mode !== m) begin
      chk("rx_mode", 32'(m), 32'(rx_mode));
      complete_run();
    end
  endtask
  // ==========================================
  // design, far end and clock
  assign cpw = exp_cpw(sel_a, sel_b);
  always #25 sys_clk = ~sys_clk;
  spr_ser_model ser (.sys_clk(sys_clk), .rst(rst), .run(run), .cpw(cpw),
    .next_word(next_word), .link_clk(link_clk), .lanes(lanes));
  spr_rx #(.LOSS_CYC(32), .LOCK_PERIODS(2)) dut (.sys_clk(sys_clk), .rst(rst),
    .link_clk_in(link_clk), .serial_lane_zero(lanes[0]), .serial_lane_one(lanes[1]),
    .serial_lane_two(lanes[2]), .lane_count_sel_a(sel_a), .lane_count_sel_b(sel_b),
    .receiver_on(ron), .out_clock_edge_sel(edge_sel), .bus_order_sel(order_sel),
    .pixel_bus(pix), .vertical_sync_out(vs), .horizontal_sync_out(hs),
    .data_valid_window(de), .pixel_clock_out(pclk), .parity_error_flag(perr),
    .out_drive_en(drv_en), .rx_mode(rx_mode), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rd_data(reg_rd_data), .irq(irq));
  // ==========================================
  // random words, some with parity turned wrong
  always @(posedge sys_clk) begin
    cyc++;
    ron_prev = ron;
    if (taken != edges) begin
      r1 = lfsr_step(lfsr);
      r2 = lfsr_step(r1);
      w = {r1[13:0], r2};
      w[27] = (^w[26:0]) ^ (err_en && r2[1:0] == 2'h0);
      lfsr <= r2;
      next_word <= w;
      taken = edges;
    end
  end
  // ==========================================
  // monitor: a word shows cpw + 1 cycles after its link edge
  always @(negedge sys_clk) begin
    if (!rst && !rst_prev) begin
      if (link_clk && !link_prev) begin
        due_q.push_back(cyc + int'(cpw) + 1);
        word_q.push_back(next_word);
        edges++;
      end
      if (due_q.size() > 0 && due_q[0] == cyc) begin
        cw = word_q.pop_front();
        void'(due_q.pop_front());
        bad = cw[27] ^ (^cw[26:0]);
        if (rx_mode === mode_active && prev_ok) begin
          chk("bus", {5'h0, bad ? exp_prev : exp_out(cw, order_sel)}, {5'h0, vs, hs, de, pix});
          chk("parity_error_flag", 32'(bad), 32'(perr));
          chk("pixel_clock_out", 32'(!edge_sel), 32'(pclk));
        end
        if (rx_mode !== mode_active) begin
          prev_ok = 1'b0;
        end else if (!bad) begin
          exp_prev = exp_out(cw, order_sel);
          prev_ok = 1'b1;
        end
      end
      if (rx_mode !== mode_active && mode_prev !== mode_active) begin
        chk("static bus", {5'h0, 3'h6, 24'hFFFFFF}, {5'h0, vs, hs, de, pix});
        chk("static clock flag", 32'h0, {30'h0, pclk, perr});
      end
      chk("out_drive_en", 32'(ron_prev), 32'(drv_en));
    end
    mode_prev = rx_mode;
    link_prev = link_clk;
    rst_prev = rst;
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    reg_read(`SPR_REG_MASK, rd);
    chk("mask reset", 32'h0, rd);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      run <= 1'b0;
      wait_mode(mode_standby, 200);
      if (i > 0) begin
        reg_read(`SPR_REG_STATUS, rd);
        chk("standby event", 32'h1, 32'(rd[`SPR_EV_LOST]));
        chk("lock event", 32'h1, 32'(rd[`SPR_EV_LOCK]));
      end
      if (i == 3) begin
        @(posedge sys_clk);
        ron <= 1'b0;
        run <= 1'b1;
        wait_mode(mode_shutdown, 5);
        repeat (200) @(posedge sys_clk);
        chk("shutdown held", 32'(mode_shutdown), 32'(rx_mode));
        ron <= 1'b1;
        run <= 1'b0;
        wait_mode(mode_standby, 200);
      end
      @(posedge sys_clk);
      sel_a <= i[0];
      sel_b <= i[1];
      order_sel <= i[2];
      edge_sel <= i[0] ^ i[2];
      err_en <= 1'b1;
      @(posedge sys_clk);
      run <= 1'b1;
      wait_mode(mode_active, 400);
      reg_read(`SPR_REG_STATE, rd);
      chk("state", {26'h0, 2'(`SPR_WORD_BITS / int'(cpw)), 2'(mode_active), 2'h3}, rd);
      repeat (400) @(posedge sys_clk);
    end
    chk("irq masked", 32'h0, 32'(irq));
    reg_write(`SPR_REG_MASK, 32'h1);
    err_en <= 1'b1;
    for (int k = 0; k < 600 && irq !== 1'b1; k++) begin
      @(negedge sys_clk);
    end
    chk("irq raised", 32'h1, 32'(irq));
    @(posedge sys_clk);
    run <= 1'b0;
    wait_mode(mode_standby, 200);
    reg_read(`SPR_REG_STATUS, rd);
    chk("parity event", 32'h1, 32'(rd[`SPR_EV_PERR]));
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("irq cleared", 32'h0, 32'(irq));
    reg_read(8'h0C, rd);
    chk("unmapped read", 32'h0, rd);
    reg_read(`SPR_REG_MASK, rd);
    chk("mask readback", 32'h1, rd);
    complete_run();
  end
endmodule
